// ---- rtl/fbrc_pkg.sv ----
// Shared constants and types for the flash bus and reset controller
package fbrc_pkg;

   // Clock and data bus
   localparam int          CLK_PERIOD_NS      = 4;
   localparam int          DATA_W             = 16;

   // Command written to the command interface to return to array reads
   localparam logic [15:0] CMD_READ_ARRAY     = 16'h00FF;

   // Reset timing in printed units
   localparam int          RESET_PULSE_MIN_NS = 100;
   localparam int          ABORT_ERASE_US     = 22;
   localparam int          ABORT_PROGRAM_US   = 12;

   // Reset timing in clock cycles: least time rounds up, longest rounds down
   localparam int RESET_PULSE_CYC =
      (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ABORT_ERASE_CYC   = (ABORT_ERASE_US * 1000) / CLK_PERIOD_NS;
   localparam int ABORT_PROGRAM_CYC =
      (ABORT_PROGRAM_US * 1000) / CLK_PERIOD_NS;

   // Kind of device operation that may be running when reset is requested
   typedef enum logic [1:0] {
      FBRC_OP_NONE    = 2'h0,
      FBRC_OP_PROGRAM = 2'h1,
      FBRC_OP_ERASE   = 2'h2
   } fbrc_op_t;

   // Controller sequencer states
   typedef enum logic [2:0] {
      FBRC_ST_RESET  = 3'h0,
      FBRC_ST_IDLE   = 3'h1,
      FBRC_ST_WSETUP = 3'h2,
      FBRC_ST_WPULSE = 3'h3,
      FBRC_ST_WHOLD  = 3'h4,
      FBRC_ST_RSTART = 3'h5,
      FBRC_ST_RACC   = 3'h6
   } fbrc_state_t;

endpackage

// ---- rtl/fbrc_sync.sv ----
// Two-flop synchroniser for the data bus returned by the flash
`timescale 1ns/1ps
`default_nettype none
module fbrc_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   // Data
   input  wire logic [W-1:0] d_in,
   output var  logic [W-1:0] q_out
);
   logic [W-1:0] meta;

   // First stage is read only by the second stage
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta  <= '0;
         q_out <= '0;
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/fbrc_ctrl.sv ----
// Host controller driving an asynchronous parallel flash and its reset pin
`timescale 1ns/1ps
`default_nettype none
module fbrc_ctrl
   import fbrc_pkg::*;
#(
   parameter int ADDR_W          = 22,
   parameter int ERASE_ABORT_CYC = ABORT_ERASE_CYC,
   parameter int WAKE_READ_NS    = 150,
   parameter int WAKE_WRITE_NS   = 40,
   parameter int SETUP_CYC       = 2,
   parameter int WE_LOW_CYC      = 12,
   parameter int READ_CYC        = 24
) (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_b_in,
   // User request
   input  wire logic              req_valid_in,
   input  wire logic              req_write_in,
   input  wire logic              req_array_in,
   input  wire logic [ADDR_W-1:0] req_addr_in,
   input  wire logic [15:0]       req_wdata_in,
   output var  logic              req_ready_out,
   // User read answer
   output var  logic              rsp_valid_out,
   output var  logic [15:0]       rsp_data_out,
   // User reset request and status
   input  wire logic              reset_req_in,
   input  wire logic [1:0]        reset_op_in,
   output var  logic              flash_in_reset_out,
   output var  logic              array_mode_out,
   // Flash pins
   output var  logic              reset_powerdown_n_out,
   output var  logic              ce_n_out,
   output var  logic              oe_n_out,
   output var  logic              we_n_out,
   output var  logic [ADDR_W-1:0] addr_out,
   output var  logic [15:0]       dq_out,
   output var  logic              dq_oe_n_out,
   input  wire logic [15:0]       dq_in
);
   // Cycle counts derived from the clock rate
   localparam int WAKE_RD_CYC =
      (WAKE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_WR_CYC =
      (WAKE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CYC =
      (WAKE_RD_CYC > WAKE_WR_CYC) ? WAKE_RD_CYC : WAKE_WR_CYC;
   localparam logic [15:0] PULSE_C   = 16'(RESET_PULSE_CYC);
   localparam logic [15:0] PROG_C    = 16'(ABORT_PROGRAM_CYC);
   localparam logic [15:0] ERASE_C   = 16'(ERASE_ABORT_CYC);
   localparam logic [15:0] WAKE_RD_C = 16'(WAKE_RD_CYC);
   localparam logic [15:0] WAKE_WR_C = 16'(WAKE_WR_CYC);
   localparam logic [15:0] WAKE_C    = 16'(WAKE_CYC);
   localparam logic [15:0] SETUP_C   = 16'(SETUP_CYC);
   localparam logic [15:0] WE_LOW_C  = 16'(WE_LOW_CYC);
   localparam logic [15:0] READ_C    = 16'(READ_CYC);
   localparam logic [15:0] WAKE_SAT  = 16'hFFFF;

   typedef struct packed {
      fbrc_state_t       st;
      logic [15:0]       cnt;
      logic [15:0]       hold;
      logic [15:0]       wake;
      logic              array_mode;
      logic              pend_read;
      logic [ADDR_W-1:0] addr;
      logic [15:0]       dq;
      logic              dq_oe_n;
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic              rp_n;
      logic [15:0]       rdata;
      logic              rsp_valid;
      logic              ready;
   } fbrc_regs_t;

   fbrc_regs_t  s;
   fbrc_regs_t  next_s;
   logic [15:0] dq_sync;

   // Read data crosses from the pins; READ_CYC must cover the two sync stages
   fbrc_sync #(
      .W (16)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .d_in     (dq_in),
      .q_out    (dq_sync)
   );

   // Sequencer next state
   always_comb begin
      next_s           = s;
      next_s.rsp_valid = 1'b0;
      // wake timer runs from reset release
      if (s.rp_n && s.wake != WAKE_SAT) begin
         next_s.wake = s.wake + 16'h0001;
      end
      unique case (s.st)
         FBRC_ST_RESET: begin
            next_s.cnt = s.cnt + 16'h0001;
            // release only after the full shutdown hold
            if (next_s.cnt >= s.hold) begin
               next_s.rp_n       = 1'b1;
               next_s.wake       = 16'h0000;
               next_s.array_mode = 1'b1;
               next_s.st         = FBRC_ST_IDLE;
            end
         end
         FBRC_ST_IDLE: begin
            next_s.ce_n    = 1'b1;
            next_s.oe_n    = 1'b1;
            next_s.we_n    = 1'b1;
            next_s.dq_oe_n = 1'b1;
            if (reset_req_in) begin
               // hold chosen by what the device may be running
               unique case (fbrc_op_t'(reset_op_in))
                  FBRC_OP_PROGRAM: next_s.hold = PROG_C;
                  FBRC_OP_ERASE:   next_s.hold = ERASE_C;
                  default:         next_s.hold = PULSE_C;
               endcase
               next_s.cnt  = 16'h0000;
               next_s.rp_n = 1'b0;
               next_s.st   = FBRC_ST_RESET;
            end else if (req_valid_in && s.ready) begin
               next_s.addr = req_addr_in;
               next_s.cnt  = 16'h0000;
               if (req_write_in) begin
                  // only the read-array value restores array mode
                  next_s.array_mode = (req_wdata_in == CMD_READ_ARRAY);
                  next_s.dq         = req_wdata_in;
                  next_s.pend_read  = 1'b0;
                  next_s.ce_n       = 1'b0;
                  next_s.dq_oe_n    = 1'b0;
                  next_s.st         = FBRC_ST_WSETUP;
               end else if (req_array_in && !s.array_mode) begin
                  // insert read-array command before an array read
                  next_s.array_mode = 1'b1;
                  next_s.dq         = CMD_READ_ARRAY;
                  next_s.pend_read  = 1'b1;
                  next_s.ce_n       = 1'b0;
                  next_s.dq_oe_n    = 1'b0;
                  next_s.st         = FBRC_ST_WSETUP;
               end else begin
                  next_s.ce_n = 1'b0;
                  next_s.oe_n = 1'b0;
                  next_s.st   = FBRC_ST_RACC;
               end
            end
         end
         FBRC_ST_WSETUP: begin
            next_s.cnt = s.cnt + 16'h0001;
            // write strobe with output enable high
            if (next_s.cnt >= SETUP_C) begin
               next_s.we_n = 1'b0;
               next_s.cnt  = 16'h0000;
               next_s.st   = FBRC_ST_WPULSE;
            end
         end
         FBRC_ST_WPULSE: begin
            next_s.cnt = s.cnt + 16'h0001;
            // write enable rises first, before select
            if (next_s.cnt >= WE_LOW_C) begin
               next_s.we_n = 1'b1;
               next_s.st   = FBRC_ST_WHOLD;
            end
         end
         FBRC_ST_WHOLD: begin
            // Data and select held one cycle past the latching edge
            next_s.ce_n    = 1'b1;
            next_s.dq_oe_n = 1'b1;
            next_s.st = s.pend_read ? FBRC_ST_RSTART : FBRC_ST_IDLE;
         end
         FBRC_ST_RSTART: begin
            next_s.pend_read = 1'b0;
            next_s.cnt       = 16'h0000;
            next_s.ce_n      = 1'b0;
            next_s.oe_n      = 1'b0;
            next_s.st        = FBRC_ST_RACC;
         end
         FBRC_ST_RACC: begin
            next_s.cnt = s.cnt + 16'h0001;
            if (next_s.cnt >= READ_C) begin
               next_s.rdata     = dq_sync;
               next_s.rsp_valid = 1'b1;
               next_s.ce_n      = 1'b1;
               next_s.oe_n      = 1'b1;
               next_s.st        = FBRC_ST_IDLE;
            end
         end
         default: begin
            next_s.st = FBRC_ST_IDLE;
         end
      endcase
      // accept requests only once both wake delays have run
      next_s.ready = (next_s.st == FBRC_ST_IDLE) && next_s.rp_n &&
                     (next_s.wake >= WAKE_C) && !reset_req_in;
   end

   // State register; system reset also holds the flash in reset
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         // flash reset pin low while the system is in reset
         s            <= '0;
         s.st         <= FBRC_ST_RESET;
         s.hold       <= PULSE_C;
         s.array_mode <= 1'b1;
         s.dq_oe_n    <= 1'b1;
         s.ce_n       <= 1'b1;
         s.oe_n       <= 1'b1;
         s.we_n       <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign req_ready_out         = s.ready;
   assign rsp_valid_out         = s.rsp_valid;
   assign rsp_data_out          = s.rdata;
   assign flash_in_reset_out    = !s.rp_n;
   assign array_mode_out        = s.array_mode;
   assign reset_powerdown_n_out = s.rp_n;
   assign ce_n_out              = s.ce_n;
   assign oe_n_out              = s.oe_n;
   assign we_n_out              = s.we_n;
   assign addr_out              = s.addr;
   assign dq_out                = s.dq;
   assign dq_oe_n_out           = s.dq_oe_n;

   // Helper: length of the current reset pulse
   logic [15:0] low_cnt;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         low_cnt <= 16'h0000;
      end else begin
         low_cnt <= s.rp_n ? 16'h0000 : low_cnt + 16'h0001;
      end
   end

   // Checks on the pin sequences
   a_reset_min_pulse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      $rose(s.rp_n) |-> low_cnt >= PULSE_C)
      else $error("reset pulse shorter than minimum");
   a_abort_hold_len: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      $rose(s.rp_n) |-> low_cnt == s.hold)
      else $error("reset released before shutdown hold");
   a_sys_reset_rp: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      $rose(rst_b_in) |-> !s.rp_n [*8])
      else $error("flash reset not held after system reset");
   a_read_pins_ok: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !s.oe_n |-> !s.ce_n && s.we_n && s.rp_n && s.dq_oe_n)
      else $error("bad pin levels during read");
   a_write_pins_ok: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !s.we_n |-> !s.ce_n && s.oe_n && s.rp_n && !s.dq_oe_n)
      else $error("bad pin levels during write");
   a_wake_read_wait: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      $fell(s.oe_n) |-> s.wake > WAKE_RD_C)
      else $error("read started inside wake delay");
   a_wake_write_wait: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      $fell(s.we_n) |-> s.wake > WAKE_WR_C)
      else $error("write started inside wake delay");
   a_array_before_rd: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (s.st == FBRC_ST_RACC && $past(s.st) == FBRC_ST_RSTART)
      |-> s.array_mode)
      else $error("array read without read-array mode");
   a_ff_cmd_value: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (s.st == FBRC_ST_WSETUP && s.pend_read)
      |-> s.dq == CMD_READ_ARRAY ##1 s.dq == CMD_READ_ARRAY)
      else $error("inserted command is not read-array");

   c_read_done: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      s.rsp_valid);
   c_auto_array: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      s.st == FBRC_ST_RSTART);
   c_erase_abort: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      $rose(s.rp_n) && s.hold == ERASE_C);
endmodule
`default_nettype wire

// ---- tb/fbrc_flash_model.sv ----
// Behavioural model of the parallel flash that the controller drives
`timescale 1ns/1ps
`default_nettype none
module fbrc_flash_model #(
   parameter int ACCESS_NS  = 70,
   parameter int PULSE_NS   = 100,
   parameter int PROG_NS    = 12000,
   parameter int ERASE_NS   = 160,
   parameter int WAKE_RD_NS = 150,
   parameter int WAKE_WR_NS = 40
) (
   // Free clock, paces the floating-bus pattern and samples the bus fight check
   input  wire logic        clk_in,
   // Control pins and buses from the host
   input  wire logic        reset_powerdown_n_in,
   input  wire logic        ce_n_in,
   input  wire logic        oe_n_in,
   input  wire logic        we_n_in,
   input  wire logic [21:0] addr_in,
   input  wire logic [15:0] dq_in,
   input  wire logic        dq_oe_n_in,
   input  wire logic [1:0]  op_in,
   // Answers and observations
   output var  logic [15:0] dq_out,
   output var  logic [15:0] last_cmd_out,
   output var  logic [7:0]  viol_out
);
   logic        arr_mode = 1'b1;
   logic [7:0]  status   = 8'h80;
   logic [15:0] flt      = 16'h5A5A;
   realtime     fall_t   = 0;
   realtime     base_t   = 0;
   logic [15:0] wr_a     = 16'h0000;
   logic [15:0] lost_a   = 16'h0000;
   logic        lost     = 1'b0;
   wire         wsel = reset_powerdown_n_in & ~ce_n_in & ~we_n_in;
   wire         rd_en = reset_powerdown_n_in & ~ce_n_in & ~oe_n_in & we_n_in;
   wire         rd_late;

   initial viol_out = 8'h00;
   initial last_cmd_out = 16'h0000;
   // Slow answer: data appears only after the access time
   assign #(ACCESS_NS) rd_late = rd_en;

   always @(negedge reset_powerdown_n_in) begin
      fall_t = $realtime;
      arr_mode = 1'b1;
      status = 8'h80;
      // aborted program or erase leaves its target undefined
      lost = (op_in != 2'h0);
      lost_a = wr_a;
   end

   always @(posedge reset_powerdown_n_in) begin
      if ($realtime - fall_t < PULSE_NS) viol_out = viol_out + 8'h01;
      base_t = fall_t + ((op_in == 2'h1) ? PROG_NS :
                         (op_in == 2'h2) ? ERASE_NS : PULSE_NS);
      if (base_t < $realtime) base_t = $realtime;
   end

   always @(negedge wsel) begin
      if (reset_powerdown_n_in) begin
         last_cmd_out = dq_in;
         wr_a = addr_in[15:0];
         // only 0xFF returns to array reads
         arr_mode = (dq_in[7:0] == 8'hFF);
      end
   end

   // host must wait and drive data with outputs off
   always @(posedge wsel) begin
      if ($realtime < base_t + WAKE_WR_NS || !oe_n_in || dq_oe_n_in)
         viol_out = viol_out + 8'h01;
   end

   // read must not start inside the wake interval
   always @(posedge rd_en) begin
      if ($realtime < base_t + WAKE_RD_NS) viol_out = viol_out + 8'h01;
   end

   // Bus fight check; pattern changes every cycle so stale data never passes
   always @(posedge clk_in) begin
      flt <= ~flt;
      if (rd_en && !dq_oe_n_in) viol_out = viol_out + 8'h01;
   end

   // drive only in a valid read
   assign dq_out = (rd_en & rd_late) ?
      (!arr_mode ? {8'h00, status} :
       (lost && addr_in[15:0] == lost_a) ? flt :
       (addr_in[15:0] ^ 16'h96E1)) : flt;
endmodule
`default_nettype wire

// ---- tb/flash_bus_reset_control_tb.sv ----
// Self-checking bench for the flash bus and reset controller
`timescale 1ns/1ps
`default_nettype none
module flash_bus_reset_control_tb
   import fbrc_pkg::*;
;
   localparam int ERASE_CYC = 40;
   localparam int WAKE_CYC  = 38;
   localparam int SETUP_CYC = 2;
   localparam int WE_LOW_CYC = 12;
   localparam int READ_CYC  = 24;
   // Address scramble used by the flash model for array data
   localparam logic [15:0] MIX = 16'h96E1;
   logic        clk_in, rst_b_in, req_valid, req_write, req_array;
   logic [21:0] req_addr, addr;
   logic [15:0] req_wdata, rsp_data, dq_o, dq_i, last_cmd;
   logic        req_ready, rsp_valid, reset_req, in_reset, array_mode;
   logic [1:0]  reset_op;
   logic        rp_n, ce_n, oe_n, we_n, dq_oe_n;
   logic [7:0]  viol;
   int          error_cnt = 0;
   int          samples_checked = 0;
   int          holds[3] = '{RESET_PULSE_CYC, ABORT_PROGRAM_CYC, ERASE_CYC};

   fbrc_ctrl #(
      .ERASE_ABORT_CYC (ERASE_CYC),
      .SETUP_CYC       (SETUP_CYC),
      .WE_LOW_CYC      (WE_LOW_CYC),
      .READ_CYC        (READ_CYC)
   ) DUT (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid),
      .req_write_in(req_write), .req_array_in(req_array),
      .req_addr_in(req_addr), .req_wdata_in(req_wdata),
      .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
      .rsp_data_out(rsp_data), .reset_req_in(reset_req),
      .reset_op_in(reset_op), .flash_in_reset_out(in_reset),
      .array_mode_out(array_mode), .reset_powerdown_n_out(rp_n),
      .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n), .addr_out(addr),
      .dq_out(dq_o), .dq_oe_n_out(dq_oe_n), .dq_in(dq_i));

   fbrc_flash_model #(.ERASE_NS(ERASE_CYC * CLK_PERIOD_NS)) u_flash (
      .clk_in(clk_in), .reset_powerdown_n_in(rp_n), .ce_n_in(ce_n),
      .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(addr), .dq_in(dq_o),
      .dq_oe_n_in(dq_oe_n), .op_in(reset_op), .dq_out(dq_i),
      .last_cmd_out(last_cmd), .viol_out(viol));

   // Clock at 250 MHz
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   task automatic check(input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic test_done();
      $display("Checked %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // One request; answer (read data or ready again) counted in edges
   task automatic bus(input logic w, input logic a, input logic [21:0] ad,
                      input logic [15:0] d, output logic [15:0] q,
                      output int n);
      int k;
      k = 0;
      n = 0;
      q = 16'h0000;
      req_write = w;
      req_array = a;
      req_addr = ad;
      req_wdata = d;
      req_valid = 1'b1;
      do begin @(posedge clk_in); k++; end
      while (req_ready !== 1'b1 && k < 20000);
      #1 req_valid = 1'b0;
      // Writes land late, so wait for ready before anyone looks
      do begin @(posedge clk_in); #1; n++; end
      while ((w ? req_ready : rsp_valid) !== 1'b1 && n < 200);
      if (!w) q = rsp_data;
      // A limit that runs out is a mismatch
      check(16'h0, {15'h0, k >= 20000 || n >= 200});
   endtask

   // Low-time of the reset pin, then cycles until ready
   task automatic wake(input int hold);
      int n, m;
      n = 0;
      m = 0;
      while (rp_n !== 1'b0 && n < 10) begin @(posedge clk_in); #1; n++; end
      n = 0;
      while (rp_n === 1'b0 && n < 4000) begin @(posedge clk_in); #1; n++; end
      while (req_ready !== 1'b1 && m < 200) begin @(posedge clk_in); #1; m++; end
      check(16'h1, {15'h0, n == hold});
      check(16'h1, {15'h0, m == WAKE_CYC});
      check(16'h1, {15'h0, array_mode & ~in_reset});
   endtask

   task automatic t_read();
      logic [15:0] q;
      int n;
      bus(1'b0, 1'b1, 22'h012345, 16'h0, q, n);
      check(16'h2345 ^ MIX, q);
      check(16'(READ_CYC), n[15:0]);
   endtask

   // Status mode, then array read needs an inserted 0xFF write
   task automatic t_status();
      logic [15:0] q;
      int n;
      bus(1'b1, 1'b0, 22'h000000, 16'h0070, q, n);
      check(16'(SETUP_CYC + WE_LOW_CYC + 1), n[15:0]);
      check(16'h0070, last_cmd);
      check(16'h0, {15'h0, array_mode});
      bus(1'b0, 1'b0, 22'h000000, 16'h0, q, n);
      check(16'h0080, q);
      bus(1'b0, 1'b1, 22'h3FFFFF, 16'h0, q, n);
      check(16'hFFFF ^ MIX, q);
      check(16'(READ_CYC + SETUP_CYC + WE_LOW_CYC + 2), n[15:0]);
      check(CMD_READ_ARRAY, last_cmd);
   endtask

   // Reset with each kind of running operation
   task automatic t_reset(input logic [1:0] op, input int hold);
      logic [15:0] q;
      int n;
      bus(1'b1, 1'b0, 22'h000010, 16'h0070, q, n);
      reset_op = op;
      reset_req = 1'b1;
      @(posedge clk_in);
      #1 reset_req = 1'b0;
      wake(hold);
      bus(1'b0, 1'b0, 22'h000005, 16'h0, q, n);
      check(16'h0005 ^ MIX, q);
      // Word written before an aborting reset reads back undefined
      bus(1'b0, 1'b0, 22'h000010, 16'h0, q, n);
      check(16'h1, {15'h0, (op == 2'h0) == (q == (16'h0010 ^ MIX))});
   endtask

   // Reset request during a read is refused
   task automatic t_refuse();
      logic [15:0] q;
      int n, lows;
      lows = 0;
      reset_op = 2'h0;
      fork
         bus(1'b0, 1'b1, 22'h000ABC, 16'h0, q, n);
         begin
            repeat (3) @(posedge clk_in);
            #1 reset_req = 1'b1;
            repeat (20) begin @(posedge clk_in); lows += (rp_n === 1'b0); end
            #1 reset_req = 1'b0;
         end
      join
      check(16'h0, lows[15:0]);
      check(16'h0ABC ^ MIX, q);
   endtask

   // Main sequence
   initial begin
      rst_b_in = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_array = 1'b0;
      req_addr = 22'h0;
      req_wdata = 16'h0;
      reset_req = 1'b0;
      reset_op = 2'h0;
      repeat (16) @(posedge clk_in);
      #1 rst_b_in = 1'b1;
      wake(RESET_PULSE_CYC);
      t_read();
      t_status();
      for (int i = 0; i < 3; i++) t_reset(i[1:0], holds[i]);
      t_refuse();
      // Host-side timing and bus-fight checks kept by the flash model
      check(16'h0, {8'h0, viol});
      test_done();
   end

   // Watchdog well beyond the longest expected run
   initial begin
      #200000;
      error_cnt++;
      test_done();
   end
endmodule
`default_nettype wire
